//--- rtl/lsg_line_regs.sv
// Line-side gain and line-interface control register bank
//
// The address-and-strobe port is this design's own decision.
`include "lsg_regs.svh"
`default_nettype none
// Function
// - Revision register bit 6 always reads one.
// - Revision bits 5:2 report a fixed read-only line-side revision.
// - Gain bit 7 mutes transmit path when set.
// - Transmit attenuation bits 6:4 give 0/3/6/9 dB, 12 dB when top bit set.
// - Bit 3 mutes receive; bits 2:0 select receive gain likewise.
// - Bits 7 and 5 pick ac termination per variant; single variants ignore.
// - On the four variant only, on-hook speed bit with second bit and quench field sets release time; other variants always release fast.
// - Bit 4 selects IIR over FIR, only with the faster system-side clock.
// - Bit 1 selects synthesized ringer impedance where the variant supports it.
// - Bit 0 selects higher ring threshold band except on limited variants.
module lsg_line_regs
   import lsg_pkg::*;
#(
   parameter logic [3:0] LINE_REVISION = 4'h1, // Arbitrary value
   parameter lsg_variant_t VARIANT = LSG_VAR_FOUR,
   parameter bit FAST_SYS_CLOCK = 1'b1
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Settings kept outside this bank
   input wire logic onhook_speed_second,
   input wire logic [1:0] spark_quench_sel,
   // Decoded controls
   output logic tx_mute,
   output lsg_step_t tx_atten,
   output logic rx_mute,
   output lsg_step_t rx_gain,
   output lsg_term_t termination,
   output lsg_onhook_t onhook_time,
   output logic recursive_filter_active,
   output logic ringer_synth_active,
   output logic ring_threshold_high
);
   // ==========================================================
   // Storage
   logic [7:0] gain_ctrl;
   logic [7:0] line_ctrl;
   logic [7:0] next_rdata;
   logic [7:0] revision_value;
   lsg_step_t next_tx_atten;
   lsg_step_t next_rx_gain;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         gain_ctrl <= `LSG_GAIN_RESET;
      else if (wr && addr == `LSG_OFF_GAIN)
         gain_ctrl <= wdata;
   end

   // Reserved bits 3:2 never stored
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         line_ctrl <= `LSG_LINE_RESET;
      else if (wr && addr == `LSG_OFF_LINE)
         line_ctrl <= wdata & `LSG_LINE_WMASK;
   end

   // ==========================================================
   // Read port
   always_comb
   begin
      revision_value = 8'h00;
      revision_value[`LSG_REV_ONE_BIT] = 1'b1;
      revision_value[`LSG_REV_LO +: 4] = LINE_REVISION;
   end

   always_comb
   begin
      case (addr)
         `LSG_OFF_REVISION: next_rdata = revision_value;
         `LSG_OFF_GAIN: next_rdata = gain_ctrl;
         `LSG_OFF_LINE: next_rdata = line_ctrl;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   // ==========================================================
   // Gain decode
   lsg_step_decode u_tx_dec
   (
      .code(gain_ctrl[`LSG_GAIN_TXA_LO +: 3]),
      .step(next_tx_atten)
   );

   lsg_step_decode u_rx_dec
   (
      .code(gain_ctrl[`LSG_GAIN_RXG_LO +: 3]),
      .step(next_rx_gain)
   );

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_mute <= 1'b0;
         tx_atten <= LSG_DB0;
         rx_mute <= 1'b0;
         rx_gain <= LSG_DB0;
      end
      else
      begin
         tx_mute <= gain_ctrl[`LSG_GAIN_TXM];
         tx_atten <= next_tx_atten;
         rx_mute <= gain_ctrl[`LSG_GAIN_RXM];
         rx_gain <= next_rx_gain;
      end
   end

   // ==========================================================
   // Line interface decode
   logic termination_sel_hi;
   logic termination_sel_lo;
   logic onhook_speed;
   lsg_term_t next_termination;
   lsg_onhook_t next_onhook;

   assign termination_sel_hi = line_ctrl[`LSG_LINE_ACT_HI];
   assign termination_sel_lo = line_ctrl[`LSG_LINE_ACT_LO];
   assign onhook_speed = line_ctrl[`LSG_LINE_OHS];

   always_comb
   begin
      case (VARIANT)
         LSG_VAR_FOUR: next_termination = lsg_term_t'({termination_sel_hi,
            termination_sel_lo});
         LSG_VAR_DUAL:
            next_termination = (termination_sel_hi ^ termination_sel_lo) ?
               LSG_TERM_TBR21 : LSG_TERM_REAL600;
         default: next_termination = LSG_TERM_REAL600;
      endcase
   end

   // Unlisted combinations fall back to fast release
   always_comb
   begin
      next_onhook = LSG_OH_FAST;
      if (VARIANT == LSG_VAR_FOUR)
      begin
         if (onhook_speed && spark_quench_sel == 2'h3)
            next_onhook = LSG_OH_26MS;
         else if (!onhook_speed && onhook_speed_second && spark_quench_sel == 2'h0)
            next_onhook = LSG_OH_3MS;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         termination <= LSG_TERM_REAL600;
         onhook_time <= LSG_OH_FAST;
         recursive_filter_active <= 1'b0;
         ringer_synth_active <= 1'b0;
         ring_threshold_high <= 1'b0;
      end
      else
      begin
         termination <= next_termination;
         onhook_time <= next_onhook;
         recursive_filter_active <= FAST_SYS_CLOCK && line_ctrl[`LSG_LINE_IIR];
         ringer_synth_active <= (VARIANT == LSG_VAR_FOUR) && line_ctrl[`LSG_LINE_RZ];
         ring_threshold_high <= (VARIANT == LSG_VAR_FOUR) && line_ctrl[`LSG_LINE_RT];
      end
   end

   // ==========================================================
   // Checks
   // Decoded outputs land one edge after the write edge
   sequence s_gain_wr;
      wr && addr == `LSG_OFF_GAIN;
   endsequence

   sequence s_line_wr;
      wr && addr == `LSG_OFF_LINE;
   endsequence

   // Quench inputs are decoded one edge after the line write
   sequence s_slow_release;
      s_line_wr ##0 (VARIANT == LSG_VAR_FOUR && wdata[`LSG_LINE_OHS]) ##1
         spark_quench_sel == 2'h3;
   endsequence

   sequence s_mid_release;
      s_line_wr ##0 (VARIANT == LSG_VAR_FOUR && !wdata[`LSG_LINE_OHS]) ##1
         (onhook_speed_second && spark_quench_sel == 2'h0);
   endsequence

   // Readback three edges after a write, with no write in between
   sequence s_gain_rd_after_wr;
      s_gain_wr ##1 (!wr)[*2] ##1 (rd && addr == `LSG_OFF_GAIN);
   endsequence

   sequence s_line_rd_after_wr;
      s_line_wr ##1 (!wr)[*2] ##1 (rd && addr == `LSG_OFF_LINE);
   endsequence

   a_revision_read: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `LSG_OFF_REVISION |=> rdata == {2'b01, LINE_REVISION, 2'b00})
      else $error("revision read wrong");

   a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `LSG_OFF_RESERVED |=> rdata == 8'h00)
      else $error("reserved register not zero");

   a_line_rsvd_bits: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `LSG_OFF_LINE |=> rdata[3:2] == 2'b00)
      else $error("reserved bits set");

   a_tx_mute_follow: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `LSG_OFF_GAIN |=> ##1 tx_mute == $past(wdata[7], 2))
      else $error("tx mute not applied");

   a_tx_atten_top: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `LSG_OFF_GAIN && wdata[6] |=> ##1 tx_atten == LSG_DB12)
      else $error("tx attenuation not 12 dB");

   a_rx_gain_code: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `LSG_OFF_GAIN && wdata[2:0] == 3'h3 |=> ##1 rx_gain == LSG_DB9)
      else $error("rx gain not 9 dB");

   a_rx_mute_follow: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `LSG_OFF_GAIN |=> ##1 rx_mute == $past(wdata[3], 2))
      else $error("rx mute not applied");

   a_iir_select: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `LSG_OFF_LINE |=> ##1
      recursive_filter_active == (FAST_SYS_CLOCK && $past(wdata[4], 2)))
      else $error("filter select wrong");

   a_ring_thresh: assert property (@(posedge clock) disable iff (!rst_n)
      VARIANT != LSG_VAR_FOUR |-> !ring_threshold_high && !ringer_synth_active)
      else $error("limited variant feature active");

   a_term_single: assert property (@(posedge clock) disable iff (!rst_n)
      VARIANT == LSG_VAR_SINGLE |-> termination == LSG_TERM_REAL600)
      else $error("single variant termination changed");

   a_onhook_limited: assert property (@(posedge clock) disable iff (!rst_n)
      VARIANT != LSG_VAR_FOUR |-> onhook_time == LSG_OH_FAST)
      else $error("limited variant slow release");

   a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
      !rd |=> rdata == 8'h00)
      else $error("read data not cleared");

   a_gain_readback: assert property (@(posedge clock) disable iff (!rst_n)
      s_gain_rd_after_wr |=> rdata == $past(wdata, 4))
      else $error("gain readback wrong");

   a_line_readback: assert property (@(posedge clock) disable iff (!rst_n)
      s_line_rd_after_wr |=> rdata == ($past(wdata, 4) & `LSG_LINE_WMASK))
      else $error("line readback wrong");

   a_tx_atten_low: assert property (@(posedge clock) disable iff (!rst_n)
      s_gain_wr ##0 !wdata[6] |=> ##1 tx_atten == lsg_step_t'({1'b0, $past(wdata[5:4], 2)}))
      else $error("tx attenuation step wrong");

   a_rx_gain_top: assert property (@(posedge clock) disable iff (!rst_n)
      s_gain_wr ##0 wdata[2] |=> ##1 rx_gain == LSG_DB12)
      else $error("rx gain not 12 dB");

   a_rx_gain_low: assert property (@(posedge clock) disable iff (!rst_n)
      s_gain_wr ##0 !wdata[2] |=> ##1 rx_gain == lsg_step_t'({1'b0, $past(wdata[1:0], 2)}))
      else $error("rx gain step wrong");

   a_term_four: assert property (@(posedge clock) disable iff (!rst_n)
      s_line_wr ##0 (VARIANT == LSG_VAR_FOUR) |=> ##1
      termination == lsg_term_t'({$past(wdata[7], 2), $past(wdata[5], 2)}))
      else $error("four variant termination wrong");

   a_term_dual: assert property (@(posedge clock) disable iff (!rst_n)
      s_line_wr ##0 (VARIANT == LSG_VAR_DUAL) |=> ##1
      termination == (($past(wdata[7], 2) != $past(wdata[5], 2)) ?
      LSG_TERM_TBR21 : LSG_TERM_REAL600))
      else $error("dual variant termination wrong");

   a_onhook_slow: assert property (@(posedge clock) disable iff (!rst_n)
      s_slow_release |=> onhook_time == LSG_OH_26MS)
      else $error("slow release not selected");

   a_onhook_mid: assert property (@(posedge clock) disable iff (!rst_n)
      s_mid_release |=> onhook_time == LSG_OH_3MS)
      else $error("3 ms release not selected");

   a_ring_four: assert property (@(posedge clock) disable iff (!rst_n)
      s_line_wr ##0 (VARIANT == LSG_VAR_FOUR) |=> ##1
      ringer_synth_active == $past(wdata[1], 2) && ring_threshold_high == $past(wdata[0], 2))
      else $error("ringer or threshold select wrong");
endmodule // lsg_line_regs
`default_nettype wire

//--- rtl/lsg_pkg.sv
// Types shared by the line-side gain/termination bank
`default_nettype none
package lsg_pkg;
   typedef enum logic [2:0] {LSG_DB0, LSG_DB3, LSG_DB6, LSG_DB9, LSG_DB12} lsg_step_t;
   typedef enum logic [1:0] {LSG_TERM_REAL600, LSG_TERM_GLOBAL, LSG_TERM_TBR21,
      LSG_TERM_NZ} lsg_term_t;
   typedef enum logic [1:0] {LSG_OH_FAST, LSG_OH_3MS, LSG_OH_26MS} lsg_onhook_t;
   // Variant capability sets
   typedef enum logic [1:0] {LSG_VAR_SINGLE, LSG_VAR_FOUR, LSG_VAR_DUAL} lsg_variant_t;
endpackage
`default_nettype wire

//--- rtl/lsg_regs.svh
// Register offsets, field positions and reset values of the line-side gain/termination bank
`ifndef LSG_REGS_SVH
`define LSG_REGS_SVH
`define LSG_OFF_REVISION 8'h0d
`define LSG_OFF_RESERVED 8'h0e
`define LSG_OFF_GAIN 8'h0f
`define LSG_OFF_LINE 8'h10
`define LSG_GAIN_RESET 8'h00
`define LSG_LINE_RESET 8'h00
`define LSG_LINE_WMASK 8'hf3
`define LSG_REV_ONE_BIT 6
`define LSG_REV_LO 2
`define LSG_GAIN_TXM 7
`define LSG_GAIN_TXA_LO 4
`define LSG_GAIN_RXM 3
`define LSG_GAIN_RXG_LO 0
`define LSG_LINE_ACT_HI 7
`define LSG_LINE_OHS 6
`define LSG_LINE_ACT_LO 5
`define LSG_LINE_IIR 4
`define LSG_LINE_RZ 1
`define LSG_LINE_RT 0
`endif

//--- rtl/lsg_step_decode.sv
// Decoder for a 3-bit gain/attenuation code into a 3 dB step
`default_nettype none
module lsg_step_decode
   import lsg_pkg::*;
(
   // Code in
   input wire logic [2:0] code,
   // Decoded step
   output lsg_step_t step
);
   always_comb
   begin
      if (code[2])
         step = LSG_DB12;
      else
      begin
         case (code[1:0])
            2'h0: step = LSG_DB0;
            2'h1: step = LSG_DB3;
            2'h2: step = LSG_DB6;
            default: step = LSG_DB9;
         endcase
      end
   end
endmodule // lsg_step_decode
`default_nettype wire

//--- testbench/lsg_line_regs_test.sv
// Self-checking bench of the line-side gain/termination bank
`default_nettype none
module lsg_line_regs_test
   import lsg_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] REV = 4'h5;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, speed2, tx_mute, rx_mute, filt, synth, thr_hi;
   logic [1:0] quench;
   lsg_step_t tx_atten, rx_gain;
   lsg_term_t termination;
   lsg_onhook_t onhook_time;
   logic [7:0] lim_rdata;
   logic lim_filt, lim_synth, lim_thr;
   lsg_term_t lim_term;
   lsg_onhook_t lim_onhook;
   int err_total = 0;
   int checked = 0;
   always #12.5 clock = ~clock;
   lsg_sys_model sys_u (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   lsg_line_regs #(.LINE_REVISION(REV)) dut_u (.clock(clock), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .onhook_speed_second(speed2), .spark_quench_sel(quench),
      .tx_mute(tx_mute), .tx_atten(tx_atten), .rx_mute(rx_mute),
      .rx_gain(rx_gain), .termination(termination), .onhook_time(onhook_time),
      .recursive_filter_active(filt), .ringer_synth_active(synth),
      .ring_threshold_high(thr_hi));
   // Limited variant on the same bus, slow system-side clock
   lsg_line_regs #(.VARIANT(LSG_VAR_DUAL), .FAST_SYS_CLOCK(1'b0)) lim_u (.clock(clock),
      .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(lim_rdata),
      .onhook_speed_second(speed2), .spark_quench_sel(quench), .tx_mute(), .tx_atten(),
      .rx_mute(), .rx_gain(), .termination(lim_term), .onhook_time(lim_onhook),
      .recursive_filter_active(lim_filt), .ringer_synth_active(lim_synth),
      .ring_threshold_high(lim_thr));
   // ==========
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] stp(input logic [2:0] c);
      return c[2] ? 8'h04 : {6'h00, c[1:0]};
   endfunction
   // Decoded outputs trail the write edge by one edge
   task automatic settle();
      @(posedge clock);
      #1;
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========
   // Tests
   task automatic t_reset();
      logic [7:0] q;
      chk({tx_mute, rx_mute, filt, synth, thr_hi, 3'h0}, 8'h00);
      chk({2'h0, tx_atten, rx_gain}, 8'h00);
      chk({4'h0, termination, onhook_time}, 8'h00);
      sys_u.get(8'h0f, q);
      chk(q, 8'h00);
      sys_u.get(8'h10, q);
      chk(q, 8'h00);
      $display("Test reset done");
   endtask
   task automatic t_ids();
      logic [7:0] q;
      sys_u.put(8'h0d, 8'hff);
      sys_u.put(8'h0e, 8'hff);
      sys_u.get(8'h0d, q);
      chk(q, {2'h1, REV, 2'h0});
      sys_u.get(8'h0e, q);
      chk(q, 8'h00);
      sys_u.get(8'h20, q);
      chk(q, 8'h00);
      $display("Test ids done");
   endtask
   task automatic t_gain();
      logic [7:0] w, q;
      for (int c = 0; c < 8; c++)
      begin
         w = {c[0], 3'(c), ~c[0], 3'(7 - c)};
         sys_u.put(8'h0f, w);
         settle();
         chk({7'h0, tx_mute}, {7'h0, w[7]});
         chk(8'(tx_atten), stp(w[6:4]));
         chk({7'h0, rx_mute}, {7'h0, w[3]});
         chk(8'(rx_gain), stp(w[2:0]));
         sys_u.get(8'h0f, q);
         chk(q, w);
      end
      $display("Test gain done");
   endtask
   task automatic t_line();
      logic [7:0] w, q, e;
      for (int c = 0; c < 8; c++)
      begin
         @(posedge clock);
         speed2 <= c[0];
         quench <= {2{c[2] | (c[1] & c[0])}};
         w = {c[1], c[2], c[0], c[2], 2'h3, c[1], c[0]};
         sys_u.put(8'h10, w);
         settle();
         chk(8'(termination), {6'h00, w[7], w[5]});
         chk({5'h0, filt, synth, thr_hi}, {5'h0, w[4], w[1:0]});
         e = w[6] ? (quench == 2'h3 ? 8'(LSG_OH_26MS) : 8'(LSG_OH_FAST))
            : (quench == 2'h0 && speed2 ? 8'(LSG_OH_3MS) : 8'(LSG_OH_FAST));
         chk(8'(onhook_time), e);
         chk(8'(lim_term), (w[7] ^ w[5]) ? 8'(LSG_TERM_TBR21) : 8'(LSG_TERM_REAL600));
         chk({5'h0, lim_filt, lim_synth, lim_thr}, 8'h00);
         chk(8'(lim_onhook), 8'(LSG_OH_FAST));
         sys_u.get(8'h10, q);
         chk(q, w & 8'hf3);
         chk(lim_rdata, w & 8'hf3);
      end
      $display("Test line done");
   endtask
   // ==========
   // Sequence
   initial
   begin
      speed2 = 1'b0;
      quench = 2'h0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      t_reset();
      t_ids();
      t_gain();
      t_line();
      wrap_up();
   end
   // Cuts a hang short
   initial
   begin
      #1ms;
      err_total++;
      wrap_up();
   end
endmodule // lsg_line_regs_test
`default_nettype wire

//--- testbench/lsg_sys_model.sv
// System-side partner that drives the register port
`default_nettype none
module lsg_sys_model (
   // Clock
   input wire logic clock,
   // Register port
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {addr, wdata, wr, rd} = '0;
   // ==========
   // Bus cycles
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      // Released data must not look like a held value
      wdata <= ~d;
   endtask
   task automatic get(input logic [7:0] a, output logic [7:0] q);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
endmodule // lsg_sys_model
`default_nettype wire
